// *** logic/gauge_setup_menu_fsm.sv ***
/*
  Front-panel setup menu, calibration store and setpoint relay control.
  Assumes raw_pressure comes from on-clock measurement logic; keys and
  relay inhibit are pins from outside; APB master on core_clk.
*/
// The register offsets and the APB interface to the registers are this design's own decisions.
`timescale 1ns/1ps
module gauge_setup_menu_fsm #(
  parameter int unsigned HOLD_SEL = gauge_pkg::HOLD_SEL_CYC,
  parameter int unsigned HOLD_DEF = gauge_pkg::HOLD_DEF_CYC,
  parameter int unsigned DEBOUNCE = gauge_pkg::DEBOUNCE_CYC
) (
  input wire logic core_clk,
  input wire logic sys_rst,
  input wire logic ce,
  input wire logic key_sel,
  input wire logic key_up,
  input wire logic key_dn,
  input wire logic relay_inhibit_n,
  input wire logic [gauge_pkg::PW-1:0] raw_pressure,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  output gauge_pkg::panel_t panel,
  output gauge_pkg::disp_t disp,
  output logic [gauge_pkg::PW-1:0] analog_code
);
  localparam int PW = gauge_pkg::PW;
  localparam int TW = gauge_pkg::TW;
  localparam int K_SEL = 0; // Key index: select
  localparam int K_UP = 1; // Key index: up
  localparam int K_DN = 2; // Key index: down

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  // Step an edited value, clamped at both ends
  function automatic logic [PW-1:0] adj(input logic [PW-1:0] v, input logic up,
                                        input logic dn, input logic [PW-1:0] step);
    logic [PW:0] s;
    s = {1'b0, v};
    if (up) begin
      s = s + {1'b0, step};
      if (s[PW]) s = {1'b0, {PW{1'b1}}};
    end else if (dn) begin
      s = (v > step) ? s - {1'b0, step} : '0;
    end
    return s[PW-1:0];
  endfunction : adj

  // Zero offset then span gain around the factory atmosphere point
  function automatic logic [PW-1:0] cal(input logic [PW-1:0] raw,
                                        input logic [PW-1:0] zero, input logic [PW-1:0] atm);
    logic [PW-1:0] x;
    logic signed [PW:0] d;
    logic signed [2*PW+1:0] p;
    logic signed [2*PW+1:0] y;
    x = (raw > zero) ? raw - zero : '0;
    d = $signed({1'b0, atm}) - $signed({1'b0, gauge_pkg::ATM_DEF});
    p = $signed({1'b0, x}) * d;
    y = $signed({{(PW+2){1'b0}}, x}) + (p >>> gauge_pkg::SPAN_SHIFT);
    if (y < 0) return '0;
    if (y > $signed({{(PW+2){1'b0}}, {PW{1'b1}}})) return {PW{1'b1}};
    return y[PW-1:0];
  endfunction : cal

  // ----------------------------------------------------------------
  // Key synchronisers and debouncers
  // ----------------------------------------------------------------
  logic [3:0] s1_r; // First stage, read only by s2_r
  logic [3:0] s2_r; // Second stage: inhibit plus three keys
  logic [2:0] db_r, db_nxt; // Debounced key levels
  logic [2:0] dbd_r, dbd_nxt; // Delayed levels for edges
  logic [TW-1:0] dbc_r [3]; // Settle counters
  logic [TW-1:0] dbc_nxt [3];
  logic [2:0] prs; // Press edges
  logic [2:0] rel; // Release edges

  // Each key must sit at a new level for the whole settle time
  always_comb begin
    db_nxt = db_r;
    dbd_nxt = db_r;
    for (int i = 0; i < 3; i++) begin
      dbc_nxt[i] = '0;
      if (s2_r[i] != db_r[i]) begin
        dbc_nxt[i] = dbc_r[i] + 1'b1;
        if (dbc_r[i] >= TW'(DEBOUNCE - 1)) begin
          db_nxt[i] = s2_r[i];
          dbc_nxt[i] = '0;
        end
      end
    end
  end

  assign prs = db_r & ~dbd_r;
  assign rel = ~db_r & dbd_r;

  // Register the key path
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      s1_r <= 4'h0;
      s2_r <= 4'h0;
      db_r <= 3'h0;
      dbd_r <= 3'h0;
      for (int i = 0; i < 3; i++) dbc_r[i] <= '0;
    end else if (ce) begin
      s1_r <= {relay_inhibit_n, key_dn, key_up, key_sel};
      s2_r <= s1_r;
      db_r <= db_nxt;
      dbd_r <= dbd_nxt;
      for (int i = 0; i < 3; i++) dbc_r[i] <= dbc_nxt[i];
    end
  end

  // ----------------------------------------------------------------
  // Menu state machine and stored settings
  // ----------------------------------------------------------------
  gauge_pkg::menu_t st_r, st_nxt;
  logic [TW-1:0] tmr_r, tmr_nxt; // Hold time of the watched key
  logic armed_r, armed_nxt; // Select pressed anew in this state
  logic [PW-1:0] edit_r, edit_nxt; // Value under edit
  logic [PW-1:0] on_r, on_nxt; // Relay turn-on pressure
  logic [PW-1:0] off_r, off_nxt; // Relay turn-off pressure
  logic [PW-1:0] zero_r, zero_nxt; // Vacuum zero
  logic [PW-1:0] atm_r, atm_nxt; // Atmosphere span value
  logic [PW-1:0] corr; // Corrected pressure
  logic held; // Watched key is down
  logic apb_wr; // APB write takes effect
  logic pready_r;

  assign apb_wr = psel & penable & pready_r & pwrite;
  assign corr = cal(raw_pressure, zero_r, atm_r);
  // The defaults hold watches up; every other hold watches select
  assign held = (st_r == gauge_pkg::S_DEF) ? db_r[K_UP] : db_r[K_SEL];

  // Next state; panel actions override an APB write in the same cycle
  always_comb begin
    st_nxt = st_r;
    armed_nxt = armed_r;
    edit_nxt = edit_r;
    on_nxt = on_r;
    off_nxt = off_r;
    zero_nxt = zero_r;
    atm_nxt = atm_r;
    tmr_nxt = held ? ((&tmr_r) ? tmr_r : tmr_r + 1'b1) : '0;
    if (prs[K_SEL]) armed_nxt = 1'b1;
    if (apb_wr) begin
      case (paddr)
        gauge_pkg::A_ON: on_nxt = pwdata[PW-1:0];
        gauge_pkg::A_OFF: off_nxt = pwdata[PW-1:0];
        gauge_pkg::A_ZERO: zero_nxt = pwdata[PW-1:0];
        gauge_pkg::A_ATM: atm_nxt = pwdata[PW-1:0];
        default: ;
      endcase
    end
    case (st_r)
      gauge_pkg::S_READ: begin
        if (armed_r && held && tmr_r >= TW'(HOLD_SEL)) begin
          st_nxt = gauge_pkg::S_ON;
          edit_nxt = on_r;
        end else if (prs[K_UP]) begin
          st_nxt = gauge_pkg::S_DEF;
        end
      end
      gauge_pkg::S_DEF: begin
        if (!held) begin
          st_nxt = gauge_pkg::S_READ;
        end else if (tmr_r >= TW'(HOLD_DEF)) begin
          on_nxt = gauge_pkg::ON_DEF;
          off_nxt = gauge_pkg::OFF_DEF;
          zero_nxt = gauge_pkg::ZERO_DEF;
          atm_nxt = gauge_pkg::ATM_DEF;
          st_nxt = gauge_pkg::S_READ;
        end
      end
      gauge_pkg::S_ON: begin
        edit_nxt = adj(edit_r, prs[K_UP], prs[K_DN], gauge_pkg::STEP_SP);
        if (prs[K_SEL]) begin
          on_nxt = edit_r;
          edit_nxt = off_r;
          st_nxt = gauge_pkg::S_OFF;
        end
      end
      gauge_pkg::S_OFF: begin
        edit_nxt = adj(edit_r, prs[K_UP], prs[K_DN], gauge_pkg::STEP_SP);
        if (prs[K_SEL]) begin
          off_nxt = edit_r;
          st_nxt = gauge_pkg::S_VAC;
        end
      end
      gauge_pkg::S_VAC: begin
        if (prs[K_SEL]) begin
          st_nxt = gauge_pkg::S_ATM;
          edit_nxt = atm_r;
        end else if (prs[K_DN]) begin
          zero_nxt = raw_pressure;
          st_nxt = gauge_pkg::S_ATM;
          edit_nxt = atm_r;
        end
      end
      gauge_pkg::S_ATM: begin
        edit_nxt = adj(edit_r, prs[K_UP], prs[K_DN], gauge_pkg::STEP_ATM);
        if (armed_r && held && tmr_r >= TW'(HOLD_SEL)) begin
          atm_nxt = edit_r;
          st_nxt = gauge_pkg::S_READ;
        end else if (armed_r && rel[K_SEL]) begin
          st_nxt = gauge_pkg::S_READ;
        end
      end
      default: st_nxt = gauge_pkg::S_READ;
    endcase
    // A new state starts its own hold count and needs a fresh press
    if (st_nxt != st_r) begin
      tmr_nxt = '0;
      armed_nxt = 1'b0;
    end
  end

  // Register the menu and settings
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      st_r <= gauge_pkg::S_READ;
      tmr_r <= '0;
      armed_r <= 1'b0;
      edit_r <= '0;
      on_r <= gauge_pkg::ON_DEF;
      off_r <= gauge_pkg::OFF_DEF;
      zero_r <= gauge_pkg::ZERO_DEF;
      atm_r <= gauge_pkg::ATM_DEF;
    end else if (ce) begin
      st_r <= st_nxt;
      tmr_r <= tmr_nxt;
      armed_r <= armed_nxt;
      edit_r <= edit_nxt;
      on_r <= on_nxt;
      off_r <= off_nxt;
      zero_r <= zero_nxt;
      atm_r <= atm_nxt;
    end
  end

  // ----------------------------------------------------------------
  // Relay, lamps, readout and analog code
  // ----------------------------------------------------------------
  gauge_pkg::panel_t panel_r, panel_nxt;
  gauge_pkg::disp_t disp_r, disp_nxt;
  logic [PW-1:0] ana_r, ana_nxt;

  // Relay keeps its level between the two setpoints
  always_comb begin
    panel_nxt = panel_r;
    if (!s2_r[3]) begin
      panel_nxt.relay = 1'b0;
    end else if (corr < on_r) begin
      panel_nxt.relay = 1'b1;
    end else if (corr > off_r) begin
      panel_nxt.relay = 1'b0;
    end
    // Red for bar, green for mbar, both for the milli range
    panel_nxt.red = (corr >= gauge_pkg::BAR_LIM) || (corr < gauge_pkg::MBAR_LIM);
    panel_nxt.green = (corr < gauge_pkg::BAR_LIM);
    ana_nxt = corr;
    disp_nxt.value = edit_r;
    case (st_r)
      gauge_pkg::S_READ: begin
        disp_nxt.mode = gauge_pkg::DM_PRESS;
        disp_nxt.value = corr;
      end
      gauge_pkg::S_DEF: begin
        disp_nxt.mode = gauge_pkg::DM_DEF;
        disp_nxt.value = '0;
      end
      gauge_pkg::S_ON: disp_nxt.mode = gauge_pkg::DM_SETON;
      gauge_pkg::S_OFF: disp_nxt.mode = gauge_pkg::DM_SETOFF;
      gauge_pkg::S_VAC: begin
        disp_nxt.mode = gauge_pkg::DM_ZERO;
        disp_nxt.value = '0;
      end
      gauge_pkg::S_ATM: disp_nxt.mode = gauge_pkg::DM_ATM;
      default: disp_nxt.mode = gauge_pkg::DM_PRESS;
    endcase
  end

  // Register the panel outputs
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      panel_r <= '0;
      disp_r <= '0;
      ana_r <= '0;
    end else if (ce) begin
      panel_r <= panel_nxt;
      disp_r <= disp_nxt;
      ana_r <= ana_nxt;
    end
  end

  assign panel = panel_r;
  assign disp = disp_r;
  assign analog_code = ana_r;

  // ----------------------------------------------------------------
  // APB slave: one wait-free access phase
  // ----------------------------------------------------------------
  logic [31:0] prdata_r, prdata_nxt;
  logic pready_nxt;
  logic pslverr_r, pslverr_nxt;

  // Read data is captured in the setup cycle so it comes from a flop
  always_comb begin
    pready_nxt = psel & ~penable;
    // Error flag stands only with its own ready pulse, never past it
    pslverr_nxt = 1'b0;
    prdata_nxt = prdata_r;
    if (psel && !penable) begin
      pslverr_nxt = 1'b0;
      prdata_nxt = '0;
      case (paddr)
        gauge_pkg::A_ON: prdata_nxt[PW-1:0] = on_r;
        gauge_pkg::A_OFF: prdata_nxt[PW-1:0] = off_r;
        gauge_pkg::A_ZERO: prdata_nxt[PW-1:0] = zero_r;
        gauge_pkg::A_ATM: prdata_nxt[PW-1:0] = atm_r;
        gauge_pkg::A_STAT: begin
          prdata_nxt[gauge_pkg::STAT_RELAY] = panel_r.relay;
          prdata_nxt[gauge_pkg::STAT_RED] = panel_r.red;
          prdata_nxt[gauge_pkg::STAT_GREEN] = panel_r.green;
          prdata_nxt[gauge_pkg::STAT_ST_LSB +: 6] = st_r;
        end
        gauge_pkg::A_PRESS: prdata_nxt[PW-1:0] = corr;
        default: pslverr_nxt = 1'b1; // Unmapped address
      endcase
    end
  end

  // Register the bus answer
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      pready_r <= 1'b0;
      pslverr_r <= 1'b0;
      prdata_r <= '0;
    end else if (ce) begin
      pready_r <= pready_nxt;
      pslverr_r <= pslverr_nxt;
      prdata_r <= prdata_nxt;
    end
  end

  assign pready = pready_r;
  assign pslverr = pslverr_r;
  assign prdata = prdata_r;
endmodule : gauge_setup_menu_fsm

// *** logic/gauge_pkg.sv ***
/*
  Shared constants and carrier types for the gauge setup menu block.
  Assumes a 50 MHz core clock and pressure codes in units of 0.001 mbar.
*/
package gauge_pkg;
  // ----------------------------------------------------------------
  // Widths and clock
  // ----------------------------------------------------------------
  localparam int PW = 24; // Pressure code width, 0.001 mbar per count
  localparam int TW = 28; // Hold and debounce timer width
  localparam int CLK_KHZ = 50_000; // Core clock rate in kHz

  // ----------------------------------------------------------------
  // Timing, in ms as printed, then in cycles
  // ----------------------------------------------------------------
  localparam int unsigned HOLD_SEL_MS = 3000; // Select hold
  localparam int unsigned HOLD_DEF_MS = 5000; // Up hold for defaults
  localparam int unsigned DEBOUNCE_MS = 10; // Switch settle time
  localparam int unsigned HOLD_SEL_CYC = HOLD_SEL_MS * CLK_KHZ;
  localparam int unsigned HOLD_DEF_CYC = HOLD_DEF_MS * CLK_KHZ;
  localparam int unsigned DEBOUNCE_CYC = DEBOUNCE_MS * CLK_KHZ;

  // ----------------------------------------------------------------
  // Factory defaults and range limits
  // ----------------------------------------------------------------
  localparam logic [PW-1:0] ON_DEF = 24'h00_0064; // 0.10 mbar
  localparam logic [PW-1:0] OFF_DEF = 24'h00_00C8; // 0.20 mbar
  localparam logic [PW-1:0] ZERO_DEF = 24'h00_0000; // 000
  localparam logic [PW-1:0] ATM_DEF = 24'h0F_6950; // 1.01 bar
  localparam logic [PW-1:0] BAR_LIM = 24'h0F_4240; // 1000 mbar
  localparam logic [PW-1:0] MBAR_LIM = 24'h00_0064; // 0.10 mbar
  localparam logic [PW-1:0] STEP_SP = 24'h00_000A; // 0.01 mbar
  localparam logic [PW-1:0] STEP_ATM = 24'h00_03E8; // 1 mbar
  localparam int SPAN_SHIFT = 20; // Span gain fraction bits

  // ----------------------------------------------------------------
  // Register map and status fields
  // ----------------------------------------------------------------
  localparam logic [7:0] A_ON = 8'h00;
  localparam logic [7:0] A_OFF = 8'h04;
  localparam logic [7:0] A_ZERO = 8'h08;
  localparam logic [7:0] A_ATM = 8'h0C;
  localparam logic [7:0] A_STAT = 8'h10;
  localparam logic [7:0] A_PRESS = 8'h14;
  localparam int STAT_RELAY = 0;
  localparam int STAT_RED = 1;
  localparam int STAT_GREEN = 2;
  localparam int STAT_ST_LSB = 8;

  // ----------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------
  typedef enum logic [5:0] {
    S_READ = 6'h01, S_DEF = 6'h02, S_ON = 6'h04,
    S_OFF = 6'h08, S_VAC = 6'h10, S_ATM = 6'h20
  } menu_t;
  typedef enum logic [2:0] {
    DM_PRESS = 3'h0, DM_SETON = 3'h1, DM_SETOFF = 3'h2,
    DM_ZERO = 3'h3, DM_ATM = 3'h4, DM_DEF = 3'h5
  } dmode_t;
  typedef struct packed {
    dmode_t mode; // What the readout shows
    logic [PW-1:0] value; // Number shown, zero for text screens
  } disp_t;
  typedef struct packed {
    logic relay; // Setpoint relay energized
    logic red; // Red unit lamp
    logic green; // Green unit lamp
  } panel_t;
endpackage : gauge_pkg

// *** test/gauge_menu_asserts.sv ***
/* Checker for the gauge setup menu: bus handshake, lamps, relay inhibit, menu timing.
   Assumes binding to the top module with its own hold parameter. */
`timescale 1ns/1ps
module gauge_menu_asserts #(
  parameter int unsigned HOLD_SEL = 20
) (
  input logic core_clk,
  input logic sys_rst,
  input logic ce,
  input logic key_sel,
  input logic key_up,
  input logic key_dn,
  input logic relay_inhibit_n,
  input logic psel,
  input logic penable,
  input logic pready,
  input logic pslverr,
  input gauge_pkg::panel_t panel,
  input gauge_pkg::disp_t disp,
  input logic [gauge_pkg::PW-1:0] analog_code
);
  // ----------------------------------------
  // Helper counters
  // ----------------------------------------
  logic [7:0] idle_r; // Cycles with all keys released
  logic [7:0] idle_nxt;
  logic [15:0] sel_r; // Cycles the select pin stayed high
  logic [15:0] sel_nxt;
  // Saturate idle so it never wraps back into a busy window
  always_comb begin
    idle_nxt = (key_sel | key_up | key_dn) ? 8'h00 : ((idle_r == 8'hFF) ? idle_r : idle_r + 8'h01);
    sel_nxt = key_sel ? sel_r + 16'h0001 : 16'h0000;
  end
  // Register only
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      idle_r <= 8'h00;
      sel_r <= 16'h0000;
    end else if (ce) begin
      idle_r <= idle_nxt;
      sel_r <= sel_nxt;
    end
  end
  default clocking dc @(posedge core_clk); endclocking
  default disable iff (sys_rst || !ce);
  sequence apb_setup;
    psel && !penable;
  endsequence
  sequence inhibit_held;
    !relay_inhibit_n [*4];
  endsequence
  // ----------------------------------------
  // Properties
  // ----------------------------------------
  a_pready_after_setup: assert property (apb_setup |=> pready && penable)
    else $error("no ready after setup");
  a_pready_one_cycle: assert property (pready |=> !pready)
    else $error("ready longer than one cycle");
  a_slverr_with_ready: assert property (pslverr |-> pready)
    else $error("error without ready");
  a_inhibit_drops_relay: assert property (inhibit_held |=> !panel.relay)
    else $error("relay on while inhibited");
  a_green_lamp_range: assert property (!$past(sys_rst) |-> panel.green == (analog_code < gauge_pkg::BAR_LIM))
    else $error("green lamp wrong");
  a_red_lamp_range: assert property (!$past(sys_rst) |->
    panel.red == (analog_code >= gauge_pkg::BAR_LIM || analog_code < gauge_pkg::MBAR_LIM))
    else $error("red lamp wrong");
  a_text_screen_value: assert property (disp.mode inside {gauge_pkg::DM_ZERO, gauge_pkg::DM_DEF} |-> disp.value == 0)
    else $error("text screen shows a number");
  a_idle_mode_stable: assert property (idle_r >= 8'h0C |-> $stable(disp.mode))
    else $error("screen moved with keys idle");
  a_setup_entry_hold: assert property ($past(disp.mode) == gauge_pkg::DM_PRESS && disp.mode == gauge_pkg::DM_SETON
    |-> sel_r > 16'(HOLD_SEL))
    else $error("setup entered without full hold");
endmodule : gauge_menu_asserts

bind gauge_setup_menu_fsm gauge_menu_asserts #(.HOLD_SEL(HOLD_SEL)) u_asserts (
  .core_clk(core_clk), .sys_rst(sys_rst), .ce(ce), .key_sel(key_sel), .key_up(key_up),
  .key_dn(key_dn), .relay_inhibit_n(relay_inhibit_n), .psel(psel), .penable(penable),
  .pready(pready), .pslverr(pslverr), .panel(panel), .disp(disp), .analog_code(analog_code));

// *** test/key_operator.sv ***
/* Operator model: works the three-position switch like a person, one key at a time.
   Assumes the caller sits on a rising edge of core_clk. */
`timescale 1ns/1ps
module key_operator (
  input wire logic core_clk,
  output logic key_sel,
  output logic key_up,
  output logic key_dn
);
  logic [2:0] keys = 3'h0; // Select, up, down pin levels
  assign key_sel = keys[0];
  assign key_up = keys[1];
  assign key_dn = keys[2];
  // Press key k for n cycles, then leave the menu time to settle
  task automatic press(input int k, input int n);
    @(posedge core_clk);
    // Contact bounce, too short to count
    keys[k] <= 1'b1;
    @(posedge core_clk);
    keys[k] <= 1'b0;
    @(posedge core_clk);
    keys[k] <= 1'b1;
    repeat (n) @(posedge core_clk);
    keys[k] <= 1'b0;
    repeat (12) @(posedge core_clk);
  endtask : press
endmodule : key_operator

// *** test/gauge_setup_menu_fsm_tb.sv ***
/* Self-checking bench: APB reads of the settings, operator walks through the menu,
   relay and lamp table. Assumes short hold parameters (20, 30, 2 cycles). */
`timescale 1ns/1ps
module gauge_setup_menu_fsm_tb;
  // ----------------------------------------
  // Stimulus and design
  // ----------------------------------------
  logic core_clk = 1'b0;
  logic sys_rst = 1'b1;
  logic ce = 1'b1; // Clock enable, low freezes the block
  logic relay_inhibit_n = 1'b1; // Relay allowed
  logic [23:0] raw_pressure = 24'h00_01F4; // 0.5 mbar, relay off
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0000_0000;
  logic [31:0] prdata;
  logic pready, pslverr, key_sel, key_up, key_dn;
  gauge_pkg::panel_t panel;
  gauge_pkg::disp_t disp;
  logic [23:0] analog_code;
  logic [31:0] q; // Last read word
  logic e; // Last error flag
  int err_count = 0;
  int samples_checked = 0;
  // Relay and lamp table: pressure, inhibit, expected status
  logic [23:0] rp [7] = '{24'h00_0032, 24'h00_0096, 24'h00_00FA, 24'h00_0096, 24'h00_0032, 24'h0F_4240, 24'h00_0032};
  logic inh [7] = '{1'b1, 1'b1, 1'b1, 1'b1, 1'b0, 1'b1, 1'b1};
  logic [31:0] st [7] = '{32'h0000_0107, 32'h0000_0105, 32'h0000_0104, 32'h0000_0104, 32'h0000_0106,
    32'h0000_0102, 32'h0000_0107};
  initial begin
    forever #10 core_clk = ~core_clk;
  end
  gauge_setup_menu_fsm #(.HOLD_SEL(20), .HOLD_DEF(30), .DEBOUNCE(2)) uut (
    .core_clk(core_clk), .sys_rst(sys_rst), .ce(ce), .key_sel(key_sel), .key_up(key_up),
    .key_dn(key_dn), .relay_inhibit_n(relay_inhibit_n), .raw_pressure(raw_pressure), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .panel(panel), .disp(disp), .analog_code(analog_code));
  key_operator op (.core_clk(core_clk), .key_sel(key_sel), .key_up(key_up), .key_dn(key_dn));
  // ----------------------------------------
  // Tasks
  // ----------------------------------------
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp) begin
      err_count++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  // One APB transfer; request held until ready is sampled high
  task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge core_clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge core_clk);
    penable <= 1'b1;
    // No timeout here: if ready never comes, only the watchdog ends this wait
    do begin
      @(posedge core_clk);
    end while (pready !== 1'b1);
    q = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : xfer
  task automatic rd(input logic [7:0] a, input logic [31:0] exp);
    xfer(1'b0, a, 32'h0000_0000);
    chk(q, exp);
  endtask : rd
  // Screen mode and shown value
  task automatic scr(input gauge_pkg::dmode_t m, input logic [23:0] v);
    chk({29'h0, disp.mode}, {29'h0, m});
    chk({8'h00, disp.value}, {8'h00, v});
  endtask : scr
  task end_sim;
    $display("checks=%0d errors=%0d", samples_checked, err_count);
    if (err_count == 0 && samples_checked > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask : end_sim
  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial begin
    repeat (8) @(posedge core_clk);
    sys_rst <= 1'b0;
    rd(gauge_pkg::A_ON, 32'h0000_0064);
    rd(gauge_pkg::A_OFF, 32'h0000_00C8);
    rd(gauge_pkg::A_ZERO, 32'h0000_0000);
    rd(gauge_pkg::A_ATM, 32'h000F_6950);
    rd(gauge_pkg::A_STAT, 32'h0000_0104);
    rd(8'h18, 32'h0000_0000);
    chk({31'h0, e}, 32'h0000_0001);
    xfer(1'b1, gauge_pkg::A_ON, 32'hFF00_0096);
    rd(gauge_pkg::A_ON, 32'h0000_0096);
    op.press(0, 10);
    scr(gauge_pkg::DM_PRESS, 24'h00_01F4);
    op.press(0, 40);
    scr(gauge_pkg::DM_SETON, 24'h00_0096);
    op.press(1, 10);
    scr(gauge_pkg::DM_SETON, 24'h00_00A0);
    op.press(0, 10);
    rd(gauge_pkg::A_ON, 32'h0000_00A0);
    scr(gauge_pkg::DM_SETOFF, 24'h00_00C8);
    op.press(2, 10);
    scr(gauge_pkg::DM_SETOFF, 24'h00_00BE);
    op.press(0, 10);
    scr(gauge_pkg::DM_ZERO, 24'h00_0000);
    rd(gauge_pkg::A_OFF, 32'h0000_00BE);
    raw_pressure <= 24'h00_0005;
    op.press(2, 10);
    rd(gauge_pkg::A_ZERO, 32'h0000_0005);
    scr(gauge_pkg::DM_ATM, 24'h0F_6950);
    op.press(0, 10);
    scr(gauge_pkg::DM_PRESS, 24'h00_0000);
    rd(gauge_pkg::A_ATM, 32'h000F_6950);
    raw_pressure <= 24'h00_03E8;
    repeat (4) @(posedge core_clk);
    chk({8'h00, analog_code}, 32'h0000_03E3);
    // Clock enable low: a new pressure must not reach the code
    ce <= 1'b0;
    raw_pressure <= 24'h00_0100;
    repeat (4) @(posedge core_clk);
    chk({8'h00, analog_code}, 32'h0000_03E3);
    ce <= 1'b1;
    raw_pressure <= 24'h00_03E8;
    rd(gauge_pkg::A_PRESS, 32'h0000_03E3);
    op.press(0, 40);
    op.press(0, 10);
    op.press(0, 10);
    op.press(0, 10);
    rd(gauge_pkg::A_ZERO, 32'h0000_0005);
    op.press(1, 10);
    scr(gauge_pkg::DM_ATM, 24'h0F_6D38);
    op.press(0, 40);
    rd(gauge_pkg::A_ATM, 32'h000F_6D38);
    scr(gauge_pkg::DM_PRESS, 24'h00_03E3);
    fork
      op.press(1, 20);
      begin
        repeat (16) @(posedge core_clk);
        scr(gauge_pkg::DM_DEF, 24'h00_0000);
      end
    join
    scr(gauge_pkg::DM_PRESS, 24'h00_03E3);
    rd(gauge_pkg::A_ON, 32'h0000_00A0);
    op.press(1, 50);
    rd(gauge_pkg::A_ON, 32'h0000_0064);
    rd(gauge_pkg::A_OFF, 32'h0000_00C8);
    rd(gauge_pkg::A_ZERO, 32'h0000_0000);
    rd(gauge_pkg::A_ATM, 32'h000F_6950);
    // Relay hysteresis, inhibit and lamp ranges, row by row
    foreach (rp[i]) begin
      raw_pressure <= rp[i];
      relay_inhibit_n <= inh[i];
      repeat (8) @(posedge core_clk);
      rd(gauge_pkg::A_STAT, st[i]);
      chk({29'h0, panel}, {29'h0, st[i][0], st[i][1], st[i][2]});
    end
    end_sim();
  end
  // Watchdog: the sequence needs well under 2000 cycles
  initial begin
    repeat (20000) @(posedge core_clk);
    err_count++;
    end_sim();
  end
endmodule : gauge_setup_menu_fsm_tb
